// file: dv/sog_servo_model.sv
// Servo controller and current comparator stand-in for the overload guard bench.
`timescale 1ns/1ps
module sog_servo_model #(
  parameter int PER = 30,
  parameter int HI = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sense_high,
  input wire logic crit_int,
  output logic pwm_src,
  output logic overcurrent
);
  int cnt;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      overcurrent <= 1'b0;
    else
      overcurrent <= sense_high;
  end
  // power cut
  // Once critical is reported the controller stops commanding pulses, as a relay would.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      pwm_src <= 1'b0;
    end else begin
      cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
      pwm_src <= (cnt < HI) && !crit_int;
    end
  end
endmodule : sog_servo_model

// file: dv/tb_sog_guard.sv
// Self-checking testbench for the servo overload guard.
`timescale 1ns/1ps
module tb_sog_guard;
  localparam logic [31:0] T_WAIT = 32'h0000_0014;
  localparam logic [31:0] T_ADJ = 32'h0000_0005;
  localparam logic [31:0] T_PER = 32'h0000_0028;
  localparam logic [31:0] T_WID = 32'h0000_000a;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hf;
  logic [31:0] wb_dat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic sense_high = 1'b0;
  logic pwm_src, overcurrent, servo_drive, crit_int, irq;
  int error_cnt = 0;
  int checks_done = 0;

  always #2.5 clk = ~clk;

  sog_guard #(.WAIT_DEF(T_WAIT), .ADJ_DEF(T_ADJ), .PERIOD_DEF(T_PER), .WIDTH_DEF(T_WID)) uut (
    .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .pwm_src(pwm_src), .overcurrent(overcurrent),
    .servo_drive(servo_drive), .crit_int(crit_int), .irq(irq));

  sog_servo_model #(.PER(30), .HI(8)) servo (
    .clk(clk), .rstn(rstn), .sense_high(sense_high), .crit_int(crit_int),
    .pwm_src(pwm_src), .overcurrent(overcurrent));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] q);
    int n;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (wb_ack === 1'b1) break;
    end
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n == 20) begin
      error_cnt++;
      $display("BAD %0t bus answer missing", $time);
      finish_test();
    end
  endtask : wb_xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string what);
    logic [31:0] q;
    wb_xfer(1'b0, a, 32'h0000_0000, q);
    chk(q & m, e, what);
  endtask : rd

  task automatic pass_chk(input int n_cyc);
    logic p;
    @(negedge clk);
    p = pwm_src;
    for (int i = 0; i < n_cyc; i++) begin
      @(negedge clk);
      chk({31'h0, servo_drive}, {31'h0, p}, "pass through");
      p = pwm_src;
    end
  endtask : pass_chk

  task automatic wait_rise(output int n);
    logic p;
    p = servo_drive;
    for (n = 1; n < 200; n++) begin
      @(negedge clk);
      if (p === 1'b0 && servo_drive === 1'b1) return;
      p = servo_drive;
    end
    error_cnt++;
    $display("BAD %0t no output pulse", $time);
    finish_test();
  endtask : wait_rise

  // The first pulse after a mode change may be cut short, so the second is measured.
  task automatic pulse_chk(input int e_hi, input int e_per, input string what);
    int n, hi;
    wait_rise(n);
    wait_rise(n);
    hi = 0;
    while (servo_drive === 1'b1 && hi < 200) begin
      hi++;
      @(negedge clk);
    end
    wait_rise(n);
    chk(hi, e_hi, what);
    chk(hi + n, e_per, what);
  endtask : pulse_chk

  task automatic t_regs();
    rd(sog_pkg::REG_CTRL, 32'h0000_0003, 32'h0000_0002, "ctrl reset");
    rd(sog_pkg::REG_WAIT, 32'hffff_ffff, T_WAIT, "wait reset");
    rd(sog_pkg::REG_ADJ, 32'hffff_ffff, T_ADJ, "adj reset");
    rd(sog_pkg::REG_EV_STAT, 32'h0000_0007, 32'h0000_0000, "event reset");
    rd(8'h40, 32'hffff_ffff, 32'h0000_0000, "unmapped read");
    $display("test regs done");
  endtask : t_regs

  task automatic t_short();
    wr(sog_pkg::REG_EV_EN, 32'h0000_0001);
    pass_chk(60);
    sense_high <= 1'b1;
    repeat (3) @(posedge clk);
    rd(sog_pkg::REG_STATUS, 32'h0000_0007, 32'h0000_0005, "overload entry");
    pass_chk(5);
    sense_high <= 1'b0;
    repeat (4) @(posedge clk);
    rd(sog_pkg::REG_STATUS, 32'h0000_0003, 32'h0000_0000, "back to normal");
    @(negedge clk);
    chk({31'h0, irq}, 32'h0000_0001, "irq on overload");
    wr(sog_pkg::REG_EV_EN, 32'h0000_0000);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0000_0000, "irq masked");
    wr(sog_pkg::REG_EV_EN, 32'h0000_0001);
    wr(sog_pkg::REG_EV_CLR, 32'h0000_0001);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
    $display("test short overload done");
  endtask : t_short

  task automatic t_failsafe();
    sense_high <= 1'b1;
    repeat (10) @(posedge clk);
    rd(sog_pkg::REG_STATUS, 32'h0000_0003, 32'h0000_0001, "still waiting");
    repeat (15) @(posedge clk);
    sense_high <= 1'b0;
    rd(sog_pkg::REG_STATUS, 32'h0000_0003, 32'h0000_0003, "failsafe entry");
    pulse_chk(8 + T_ADJ, 30, "widened");
    wr(sog_pkg::REG_CTRL, 32'h0000_0000);
    pulse_chk(8 - T_ADJ, 30, "narrowed");
    wr(sog_pkg::REG_CTRL, 32'h0000_0001);
    pulse_chk(T_WID, T_PER, "generated");
    $display("test failsafe done");
  endtask : t_failsafe

  task automatic t_crit();
    int n;
    sense_high <= 1'b1;
    for (n = 0; n < 60 && crit_int !== 1'b1; n++) @(posedge clk);
    chk(n >= 18 && n <= 26, 32'h0000_0001, "critical delay");
    sense_high <= 1'b0;
    repeat (50) @(posedge clk);
    chk({31'h0, crit_int}, 32'h0000_0001, "critical held");
    rd(sog_pkg::REG_STATUS, 32'h0000_000b, 32'h0000_000a, "critical status");
    rd(sog_pkg::REG_EV_STAT, 32'h0000_0004, 32'h0000_0004, "critical event");
    $display("test critical done");
  endtask : t_crit

  task automatic t_rst();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, crit_int}, 32'h0000_0000, "reset clears");
    rstn <= 1'b1;
    wr(sog_pkg::REG_WAIT, 32'h0000_0008);
    rd(sog_pkg::REG_WAIT, 32'hffff_ffff, 32'h0000_0008, "wait set");
    sense_high <= 1'b1;
    repeat (16) @(posedge clk);
    sense_high <= 1'b0;
    rd(sog_pkg::REG_STATUS, 32'h0000_0003, 32'h0000_0003, "short wait");
    $display("test reset and wait done");
  endtask : t_rst

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_short();
    t_failsafe();
    t_crit();
    t_rst();
    finish_test();
  end
endmodule : tb_sog_guard

// file: rtl/sog_guard.sv
// Servo overload guard top: state machine, failsafe pulse paths and Wishbone registers.
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module sog_guard #(
  parameter logic [31:0] WAIT_DEF = 32'(sog_pkg::WAIT_CYC),
  parameter logic [31:0] ADJ_DEF = 32'(sog_pkg::ADJ_CYC),
  parameter logic [31:0] PERIOD_DEF = 32'(sog_pkg::FS_PERIOD_CYC),
  parameter logic [31:0] WIDTH_DEF = 32'(sog_pkg::FS_WIDTH_CYC)
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pwm_src,
  input wire logic overcurrent,
  output logic servo_drive,
  output logic crit_int,
  output logic irq
);

  sog_pkg::sog_wb_req_t req;
  sog_pkg::sog_cfg_t cfg_q;
  sog_pkg::sog_state_t state_q;
  sog_pkg::sog_state_t state_d;
  logic ovc;
  logic [31:0] wait_q;
  logic wait_done;
  logic failsafe_on;
  logic [31:0] gen_cnt_q;
  logic gen_out_q;
  logic adj_out;
  logic fs_pwm;
  logic wb_req;
  logic wr_en;
  logic [31:0] rd_mux;
  logic [sog_pkg::EV_W-1:0] ev_set;
  logic [sog_pkg::EV_W-1:0] ev_clr;
  logic [sog_pkg::EV_W-1:0] ev_stat_q;
  logic [sog_pkg::EV_W-1:0] ev_en_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                 sel: wb_sel_i, dat: wb_dat_i};

  assign ovc = overcurrent;

  assign wait_done = ((wait_q + 32'h0000_0001) >= cfg_q.wait_cnt);

  always_comb begin
    state_d = state_q;
    case (state_q)
      sog_pkg::ST_NORMAL: begin
        if (ovc) begin
          state_d = sog_pkg::ST_OVERLOAD;
        end
      end
      sog_pkg::ST_OVERLOAD: begin
        if (!ovc) begin
          state_d = sog_pkg::ST_NORMAL;
        end else if (wait_done) begin
          state_d = sog_pkg::ST_FAILSAFE;
        end
      end
      sog_pkg::ST_FAILSAFE: begin
        if (ovc && wait_done) begin
          state_d = sog_pkg::ST_CRITICAL;
        end
      end
      sog_pkg::ST_CRITICAL: begin
        state_d = sog_pkg::ST_CRITICAL;
      end
      default: begin
        state_d = sog_pkg::ST_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= sog_pkg::ST_NORMAL;
    end else begin
      state_q <= state_d;
    end
  end

  // wait counting
  // In failsafe the same counter times the persistence check, so a brief spike does not trip.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_q <= '0;
    end else if (state_d != state_q) begin
      wait_q <= '0;
    end else if ((state_q == sog_pkg::ST_OVERLOAD) ||
                 ((state_q == sog_pkg::ST_FAILSAFE) && ovc)) begin
      if (!wait_done) begin
        wait_q <= wait_q + 32'h0000_0001;
      end
    end else begin
      wait_q <= '0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crit_int <= 1'b0;
    end else if (state_d == sog_pkg::ST_CRITICAL) begin
      crit_int <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gen_cnt_q <= '0;
    end else if ((gen_cnt_q + 32'h0000_0001) >= cfg_q.period) begin
      gen_cnt_q <= '0;
    end else begin
      gen_cnt_q <= gen_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gen_out_q <= 1'b0;
    end else begin
      gen_out_q <= (gen_cnt_q < cfg_q.width);
    end
  end

  sog_width_adjust #(
    .DW(sog_pkg::DW)
  ) u_width_adjust (
    .clk(clk),
    .rstn(rstn),
    .pwm_in(pwm_src),
    .widen(cfg_q.widen),
    .delay(cfg_q.adj),
    .pwm_out(adj_out)
  );

  assign failsafe_on = (state_q == sog_pkg::ST_FAILSAFE) || (state_q == sog_pkg::ST_CRITICAL);
  assign fs_pwm = cfg_q.gen_mode ? gen_out_q : adj_out;

  // pass-through
  // One flop of latency on the pass path and two on the width-adjusted path keep the width exact and the output glitch free.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      servo_drive <= 1'b0;
    end else begin
      servo_drive <= failsafe_on ? fs_pwm : pwm_src;
    end
  end

  // Wishbone slave: one ack per request, writes commit at the acked edge.
  assign wb_req = req.cyc & req.stb;
  assign wr_en = wb_req & req.we & wb_ack_o;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q.gen_mode <= sog_pkg::CTRL_GEN_RST;
      cfg_q.widen <= sog_pkg::CTRL_WIDEN_RST;
      cfg_q.wait_cnt <= WAIT_DEF;
      cfg_q.adj <= ADJ_DEF;
      cfg_q.period <= PERIOD_DEF;
      cfg_q.width <= WIDTH_DEF;
    end else if (wr_en) begin
      if (req.adr == sog_pkg::REG_CTRL) begin
        if (req.sel[0]) begin
          cfg_q.gen_mode <= req.dat[sog_pkg::CTRL_GEN_BIT];
          cfg_q.widen <= req.dat[sog_pkg::CTRL_WIDEN_BIT];
        end
      end else if (req.adr == sog_pkg::REG_WAIT) begin
        cfg_q.wait_cnt <= merge(cfg_q.wait_cnt, req.dat, req.sel);
      end else if (req.adr == sog_pkg::REG_ADJ) begin
        cfg_q.adj <= merge(cfg_q.adj, req.dat, req.sel);
      end else if (req.adr == sog_pkg::REG_PERIOD) begin
        cfg_q.period <= merge(cfg_q.period, req.dat, req.sel);
      end else if (req.adr == sog_pkg::REG_WIDTH) begin
        cfg_q.width <= merge(cfg_q.width, req.dat, req.sel);
      end
    end
  end

  // Event sources: each entry to overload, failsafe or critical is one sticky bit.
  assign ev_set[sog_pkg::EV_OVERLOAD] = (state_d == sog_pkg::ST_OVERLOAD) &&
                                        (state_q != sog_pkg::ST_OVERLOAD);
  assign ev_set[sog_pkg::EV_FAILSAFE] = (state_d == sog_pkg::ST_FAILSAFE) &&
                                        (state_q != sog_pkg::ST_FAILSAFE);
  assign ev_set[sog_pkg::EV_CRITICAL] = (state_d == sog_pkg::ST_CRITICAL) &&
                                        (state_q != sog_pkg::ST_CRITICAL);

  assign ev_clr = (wr_en && (req.adr == sog_pkg::REG_EV_CLR) && req.sel[0]) ?
                  req.dat[sog_pkg::EV_W-1:0] : '0;

  // A set in the clearing cycle wins, so no event is lost to a late clear.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ev_stat_q <= '0;
    end else begin
      ev_stat_q <= (ev_stat_q & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ev_en_q <= sog_pkg::EV_EN_RST;
    end else if (wr_en && (req.adr == sog_pkg::REG_EV_EN) && req.sel[0]) begin
      ev_en_q <= req.dat[sog_pkg::EV_W-1:0];
    end
  end

  assign irq = |(ev_stat_q & ev_en_q);

  always_comb begin
    rd_mux = '0;
    if (req.adr == sog_pkg::REG_CTRL) begin
      rd_mux[sog_pkg::CTRL_GEN_BIT] = cfg_q.gen_mode;
      rd_mux[sog_pkg::CTRL_WIDEN_BIT] = cfg_q.widen;
    end else if (req.adr == sog_pkg::REG_WAIT) begin
      rd_mux = cfg_q.wait_cnt;
    end else if (req.adr == sog_pkg::REG_ADJ) begin
      rd_mux = cfg_q.adj;
    end else if (req.adr == sog_pkg::REG_PERIOD) begin
      rd_mux = cfg_q.period;
    end else if (req.adr == sog_pkg::REG_WIDTH) begin
      rd_mux = cfg_q.width;
    end else if (req.adr == sog_pkg::REG_STATUS) begin
      rd_mux[1:0] = state_q;
      rd_mux[sog_pkg::ST_OVC_BIT] = ovc;
      rd_mux[sog_pkg::ST_CRIT_BIT] = crit_int;
    end else if (req.adr == sog_pkg::REG_EV_STAT) begin
      rd_mux[sog_pkg::EV_W-1:0] = ev_stat_q;
    end else if (req.adr == sog_pkg::REG_EV_EN) begin
      rd_mux[sog_pkg::EV_W-1:0] = ev_en_q;
    end
  end

  // Read data is captured with the ack and held until the next request.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_dat_o <= '0;
    end else if (wb_req && !wb_ack_o) begin
      wb_dat_o <= req.we ? 32'h0000_0000 : rd_mux;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_normal_pass;
    state_q == sog_pkg::ST_NORMAL |=> servo_drive == $past(pwm_src);
  endproperty
  a_normal_pass: assert property (p_normal_pass) else $error("Normal output differs.");

  property p_enter_overload;
    state_q == sog_pkg::ST_NORMAL && ovc |=> state_q == sog_pkg::ST_OVERLOAD ##0 wait_q == '0;
  endproperty
  a_enter_overload: assert property (p_enter_overload) else $error("Overload not entered.");

  property p_overload_pass;
    state_q == sog_pkg::ST_OVERLOAD |=> servo_drive == $past(pwm_src);
  endproperty
  a_overload_pass: assert property (p_overload_pass) else $error("Overload output differs.");

  property p_wait_counts;
    state_q == sog_pkg::ST_OVERLOAD && ovc && !wait_done
      |=> wait_q == $past(wait_q) + 32'h0000_0001;
  endproperty
  a_wait_counts: assert property (p_wait_counts) else $error("Wait counter stalled.");

  property p_recover;
    state_q == sog_pkg::ST_OVERLOAD && !ovc |=> state_q == sog_pkg::ST_NORMAL;
  endproperty
  a_recover: assert property (p_recover) else $error("No return to normal.");

  property p_to_failsafe;
    state_q == sog_pkg::ST_OVERLOAD && ovc && wait_done
      |=> state_q == sog_pkg::ST_FAILSAFE ##1 servo_drive == $past(fs_pwm);
  endproperty
  a_to_failsafe: assert property (p_to_failsafe) else $error("Failsafe not taken.");

  property p_early_hold;
    state_q == sog_pkg::ST_OVERLOAD && ovc && !wait_done |=> state_q != sog_pkg::ST_FAILSAFE;
  endproperty
  a_early_hold: assert property (p_early_hold) else $error("Failsafe before wait.");

  property p_gen_drive;
    state_q == sog_pkg::ST_FAILSAFE && cfg_q.gen_mode |=> servo_drive == $past(gen_out_q);
  endproperty
  a_gen_drive: assert property (p_gen_drive) else $error("Generator not driving.");

  property p_critical;
    state_q == sog_pkg::ST_FAILSAFE && ovc && wait_done
      |=> state_q == sog_pkg::ST_CRITICAL && crit_int;
  endproperty
  a_critical: assert property (p_critical) else $error("Critical not raised.");

  property p_crit_hold;
    crit_int |=> crit_int && state_q == sog_pkg::ST_CRITICAL [*2];
  endproperty
  a_crit_hold: assert property (p_crit_hold) else $error("Critical left.");

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("Ack held two cycles.");

  property p_crit_int_on;
    state_q == sog_pkg::ST_CRITICAL |-> crit_int;
  endproperty
  a_crit_int_on: assert property (p_crit_int_on) else $error("Critical without interrupt.");

  c_recover: cover property (state_q == sog_pkg::ST_OVERLOAD ##1 state_q == sog_pkg::ST_NORMAL);
  c_failsafe: cover property (state_q == sog_pkg::ST_FAILSAFE);
  c_critical: cover property (crit_int && irq);
  c_wb_write: cover property (wr_en && req.adr == sog_pkg::REG_CTRL);

endmodule : sog_guard

// file: rtl/sog_pkg.sv
// Constants and types shared by the servo overload guard design.
package sog_pkg;

  localparam int CLK_MHZ = 200;
  localparam int WAIT_TIME_MS = 4800;
  localparam int WAIT_CYC = WAIT_TIME_MS * CLK_MHZ * 1000;
  localparam int ADJ_TIME_US = 500;
  localparam int ADJ_CYC = ADJ_TIME_US * CLK_MHZ;
  localparam int FS_PERIOD_US = 20000;
  localparam int FS_PERIOD_CYC = FS_PERIOD_US * CLK_MHZ;
  localparam int FS_WIDTH_US = 1500;
  localparam int FS_WIDTH_CYC = FS_WIDTH_US * CLK_MHZ;

  localparam int DW = 32;
  localparam int AW = 8;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WAIT = 8'h04;
  localparam logic [7:0] REG_ADJ = 8'h08;
  localparam logic [7:0] REG_PERIOD = 8'h0C;
  localparam logic [7:0] REG_WIDTH = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_EV_STAT = 8'h18;
  localparam logic [7:0] REG_EV_CLR = 8'h1C;
  localparam logic [7:0] REG_EV_EN = 8'h20;

  localparam int CTRL_GEN_BIT = 0;
  localparam int CTRL_WIDEN_BIT = 1;
  localparam logic CTRL_GEN_RST = 1'b0;
  localparam logic CTRL_WIDEN_RST = 1'b1;

  localparam int ST_OVC_BIT = 2;
  localparam int ST_CRIT_BIT = 3;

  localparam int EV_W = 3;
  localparam int EV_OVERLOAD = 0;
  localparam int EV_FAILSAFE = 1;
  localparam int EV_CRITICAL = 2;
  localparam logic [2:0] EV_EN_RST = 3'h0;

  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_OVERLOAD = 2'b01,
    ST_FAILSAFE = 2'b11,
    ST_CRITICAL = 2'b10
  } sog_state_t;

  typedef struct packed {
    logic gen_mode;
    logic widen;
    logic [DW-1:0] wait_cnt;
    logic [DW-1:0] adj;
    logic [DW-1:0] period;
    logic [DW-1:0] width;
  } sog_cfg_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [AW-1:0] adr;
    logic [3:0] sel;
    logic [DW-1:0] dat;
  } sog_wb_req_t;

endpackage : sog_pkg

// file: rtl/sog_width_adjust.sv
// Pulse width adjuster that delays one chosen edge of the incoming pulse.
`timescale 1ns/1ps
module sog_width_adjust #(
  parameter int DW = sog_pkg::DW
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pwm_in,
  input wire logic widen,
  input wire logic [DW-1:0] delay,
  output logic pwm_out
);

  logic prev_q;
  logic [DW-1:0] cnt_q;
  logic has_dly;
  logic edge_now;
  logic done;

  assign has_dly = (delay != '0);
  assign edge_now = has_dly & (widen ? (prev_q & ~pwm_in) : (~prev_q & pwm_in));
  assign done = (cnt_q >= delay);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= pwm_in;
    end
  end

  // Reset loads the counter saturated so that no stretch happens before the first edge.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '1;
    end else if (edge_now) begin
      cnt_q <= DW'(1);
    end else if (!done) begin
      cnt_q <= cnt_q + DW'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwm_out <= 1'b0;
    end else if (widen) begin
      pwm_out <= pwm_in | edge_now | ~done;
    end else begin
      pwm_out <= pwm_in & ~edge_now & done;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_widen_hold;
    widen && edge_now |=> pwm_out;
  endproperty
  a_widen_hold: assert property (p_widen_hold) else $error("Widened pulse fell early.");

  property p_narrow_cut;
    !widen && edge_now |=> !pwm_out;
  endproperty
  a_narrow_cut: assert property (p_narrow_cut) else $error("Narrowed pulse rose early.");

endmodule : sog_width_adjust
